//--- rtl/boundary_scan_tap.sv
/*
 * boundary-scan test logic: tap controller, instruction register and
 * decode, bypass, identification and boundary scan data registers, and
 * the pin multiplexing that lets test values reach the pads.
 * assumes tck comes from the board tester and is unrelated to mclk;
 * pad inputs are asynchronous to both clocks; core signals are on mclk.
 */
`default_nettype none

`include "bscan_params.svh"

// How it works
// - bypass, boundary and id registers sit in parallel between tdi and tdo.
// - boundary chain is the scan path under external test or sample/preload.
// - external test at update-ir drives latched boundary values onto pins.
// - every update stage latches on the falling test clock edge.
// - input cells only observe the pin; nothing drives the core from them.
// - each two-way pin has one enable cell and one muxed capture cell.
// - enable high and no external test: capture cell takes core output.
// - enable low or external test: capture cell takes pad input.
// - inputs observe, outputs control, two-way both; clocks, straps, test pins none.
// - instruction stages shift from tdi on rising tck in shift-ir.
// - shifted instruction becomes current only at update-ir.
// - instruction is six bits; decode picks data path and function.
// - 000001 samples pin and core values and allows preloading latches.
// - 000010 selects identification: maker, part and version.
// - 000011 floats every output and two-way pin.
// - capture-ir loads 101101 into the instruction stages.
// - 111110 clamps pins from the latches while scanning through bypass.
// - 111111 shortens the path to the one-bit bypass register.
// - sample tms/tdi rising, change tdo falling; tdo floats outside shifts.
// - tap resets on test reset or five tck cycles with tms high.
// - tap reset makes identification current; id lsb is one.
// - bypass bit loads zero in capture-dr.
module boundary_scan_tap
	import bscan_pkg::*;
#(
	parameter int N_IN = 4,
	parameter int N_OUT = 4,
	parameter int N_BIDI = 4,
	parameter logic [3:0] ID_VERSION = 4'h1, // arbitrary value
	parameter logic [15:0] ID_PART = 16'h1234, // arbitrary value
	parameter logic [10:0] ID_MANUF = 11'h055 // arbitrary value
) (
	// system clock domain
	input wire logic mclk,
	input wire logic rst_n,
	// test port
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe_n,
	// observe-only input pins
	input wire logic [N_IN-1:0] pad_i_in,
	output logic [N_IN-1:0] core_i_in,
	// output pins
	input wire logic [N_OUT-1:0] core_o_out,
	output logic [N_OUT-1:0] pad_o_out,
	output logic [N_OUT-1:0] pad_o_oe_n,
	// two-way pins
	input wire logic [N_BIDI-1:0] core_b_out,
	input wire logic [N_BIDI-1:0] core_b_oe,
	output logic [N_BIDI-1:0] core_b_in,
	input wire logic [N_BIDI-1:0] pad_b_in,
	output logic [N_BIDI-1:0] pad_b_out,
	output logic [N_BIDI-1:0] pad_b_oe_n
);

	// chain order from tdo: inputs, outputs, two-way data, two-way enables
	localparam int BSR_W = N_IN + N_OUT + 2 * N_BIDI;
	localparam int OUT_LSB = N_IN;
	localparam int BD_LSB = N_IN + N_OUT;
	localparam int BE_LSB = N_IN + N_OUT + N_BIDI;

	// ****************************************
	// tap controller
	// ****************************************
	tap_state_t state_r;
	tap_state_t state_nxt;

	always_comb begin
		case (state_r)
			ST_RESET: state_nxt = tms ? ST_RESET : ST_IDLE;
			ST_IDLE: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: state_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: state_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: state_nxt = tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: state_nxt = tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: state_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: state_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: state_nxt = tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
			default: state_nxt = ST_RESET;
		endcase
	end

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			state_r <= ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	wire in_reset = (state_r == ST_RESET);
	wire cap_dr = (state_r == ST_CAP_DR);
	wire sh_dr = (state_r == ST_SH_DR);
	wire upd_dr = (state_r == ST_UPD_DR);
	wire cap_ir = (state_r == ST_CAP_IR);
	wire sh_ir = (state_r == ST_SH_IR);
	wire upd_ir = (state_r == ST_UPD_IR);

	// ****************************************
	// instruction register
	// ****************************************
	logic [`IR_WIDTH-1:0] ir_shift_r;
	logic [`IR_WIDTH-1:0] ir_cur_r;

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir_shift_r <= `OP_CAPTURE_PATTERN;
		end else if (cap_ir) begin
			ir_shift_r <= `OP_CAPTURE_PATTERN;
		end else if (sh_ir) begin
			ir_shift_r <= {tdi, ir_shift_r[`IR_WIDTH-1:1]};
		end
	end

	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir_cur_r <= `OP_IDCODE;
		end else if (in_reset) begin
			ir_cur_r <= `OP_IDCODE;
		end else if (upd_ir) begin
			ir_cur_r <= ir_shift_r;
		end
	end

	// ****************************************
	// instruction decode
	// ****************************************
	wire op_extest = (ir_cur_r == `OP_EXTEST);
	wire op_sample = (ir_cur_r == `OP_SAMPLE);
	wire op_idcode = (ir_cur_r == `OP_IDCODE);
	wire op_float = (ir_cur_r == `OP_FLOAT);
	wire op_clamp = (ir_cur_r == `OP_CLAMP);
	dr_sel_t dr_sel;
	assign dr_sel.bsr = op_extest | op_sample;
	assign dr_sel.id = op_idcode;
	assign dr_sel.bypass = ~(dr_sel.bsr | dr_sel.id);
	pin_mode_t mode_tck;
	assign mode_tck.from_latch = op_extest | op_clamp;
	assign mode_tck.float_all = op_float;

	// ****************************************
	// bypass and identification registers
	// ****************************************
	logic bypass_r;
	logic [`ID_WIDTH-1:0] id_shift_r;
	logic [`ID_WIDTH-1:0] id_value;

	assign id_value[0] = `ID_LSB_VALUE;
	assign id_value[`ID_MANUF_LSB +: `ID_MANUF_WIDTH] = ID_MANUF;
	assign id_value[`ID_PART_LSB +: `ID_PART_WIDTH] = ID_PART;
	assign id_value[`ID_VER_LSB +: `ID_VER_WIDTH] = ID_VERSION;

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			bypass_r <= `BYPASS_CAPTURE;
		end else if (cap_dr) begin
			bypass_r <= `BYPASS_CAPTURE;
		end else if (sh_dr && dr_sel.bypass) begin
			bypass_r <= tdi;
		end
	end

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			id_shift_r <= '0;
		end else if (cap_dr && dr_sel.id) begin
			id_shift_r <= id_value;
		end else if (sh_dr && dr_sel.id) begin
			id_shift_r <= {tdi, id_shift_r[`ID_WIDTH-1:1]};
		end
	end

	// ****************************************
	// pin values seen from the test clock
	// ****************************************
	logic [N_IN-1:0] pin_i_s1_r;
	logic [N_IN-1:0] pin_i_s2_r;
	logic [N_OUT-1:0] pin_o_s1_r;
	logic [N_OUT-1:0] pin_o_s2_r;
	logic [N_BIDI-1:0] pin_bo_s1_r;
	logic [N_BIDI-1:0] pin_bo_s2_r;
	logic [N_BIDI-1:0] pin_be_s1_r;
	logic [N_BIDI-1:0] pin_be_s2_r;
	logic [N_BIDI-1:0] pin_bi_s1_r;
	logic [N_BIDI-1:0] pin_bi_s2_r;

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			pin_i_s1_r <= '0;
			pin_i_s2_r <= '0;
			pin_o_s1_r <= '0;
			pin_o_s2_r <= '0;
			pin_bo_s1_r <= '0;
			pin_bo_s2_r <= '0;
			pin_be_s1_r <= '0;
			pin_be_s2_r <= '0;
			pin_bi_s1_r <= '0;
			pin_bi_s2_r <= '0;
		end else begin
			pin_i_s1_r <= pad_i_in;
			pin_i_s2_r <= pin_i_s1_r;
			pin_o_s1_r <= pad_o_out;
			pin_o_s2_r <= pin_o_s1_r;
			pin_bo_s1_r <= pad_b_out;
			pin_bo_s2_r <= pin_bo_s1_r;
			pin_be_s1_r <= ~pad_b_oe_n;
			pin_be_s2_r <= pin_be_s1_r;
			pin_bi_s1_r <= pad_b_in;
			pin_bi_s2_r <= pin_bi_s1_r;
		end
	end

	// ****************************************
	// boundary capture vector
	// ****************************************
	wire [N_BIDI-1:0] take_core = pin_be_s2_r & {N_BIDI{~op_extest}};
	wire [N_BIDI-1:0] bidi_cap = (take_core & pin_bo_s2_r) | (~take_core & pin_bi_s2_r);
	wire [BSR_W-1:0] bsr_cap = {pin_be_s2_r, bidi_cap, pin_o_s2_r, pin_i_s2_r};

	// ****************************************
	// boundary scan register
	// ****************************************
	logic bsr_so;
	logic [BSR_W-1:0] bsr_latch;

	scan_update_reg #(
		.W(BSR_W)
	) u_bsr (
		.tck(tck),
		.trst_n(trst_n),
		.capture_en(cap_dr && dr_sel.bsr),
		.shift_en(sh_dr && dr_sel.bsr),
		.update_en(upd_dr && dr_sel.bsr),
		.tdi(tdi),
		.capture_vec(bsr_cap),
		.so(bsr_so),
		.latch_vec(bsr_latch)
	);

	// ****************************************
	// serial output on the falling edge
	// ****************************************
	wire dr_so = dr_sel.bsr ? bsr_so : (dr_sel.id ? id_shift_r[0] : bypass_r);
	wire tdo_nxt = sh_ir ? ir_shift_r[0] : dr_so;
	logic tdo_r;
	logic tdo_oe_n_r;

	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tdo_r <= `TDO_IDLE;
			tdo_oe_n_r <= 1'h1;
		end else begin
			tdo_r <= (sh_ir || sh_dr) ? tdo_nxt : `TDO_IDLE;
			tdo_oe_n_r <= ~(sh_ir || sh_dr);
		end
	end

	assign tdo = tdo_r;
	assign tdo_oe_n = tdo_oe_n_r;

	// ****************************************
	// handover toward the system clock
	// ****************************************
	pin_mode_t mode_hold_r;
	logic upd_tgl_r;

	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			mode_hold_r <= '0;
			upd_tgl_r <= 1'h0;
		end else begin
			mode_hold_r <= mode_tck;
			upd_tgl_r <= upd_tgl_r ^ (upd_dr && dr_sel.bsr);
		end
	end

	// ****************************************
	// system clock side crossings
	// ****************************************
	pin_mode_t mode_s1_r;
	pin_mode_t mode_s2_r;
	pin_mode_t mode_s3_r;
	pin_mode_t mode_use_r;
	logic tgl_s1_r;
	logic tgl_s2_r;
	logic tgl_s3_r;
	logic [BSR_W-1:0] latch_copy_r;
	logic [N_IN-1:0] pad_i_s1_r;
	logic [N_IN-1:0] pad_i_s2_r;
	logic [N_BIDI-1:0] pad_b_s1_r;
	logic [N_BIDI-1:0] pad_b_s2_r;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mode_s1_r <= '0;
			mode_s2_r <= '0;
			mode_s3_r <= '0;
			mode_use_r <= '0;
			tgl_s1_r <= 1'h0;
			tgl_s2_r <= 1'h0;
			tgl_s3_r <= 1'h0;
		end else begin
			mode_s1_r <= mode_hold_r;
			mode_s2_r <= mode_s1_r;
			mode_s3_r <= mode_s2_r;
			// two mode bits may land a cycle apart: take them once they agree
			if (mode_s2_r == mode_s3_r) begin
				mode_use_r <= mode_s3_r;
			end
			tgl_s1_r <= upd_tgl_r;
			tgl_s2_r <= tgl_s1_r;
			tgl_s3_r <= tgl_s2_r;
		end
	end

	wire latch_new = tgl_s2_r ^ tgl_s3_r;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			latch_copy_r <= '0;
		end else if (latch_new) begin
			latch_copy_r <= bsr_latch;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pad_i_s1_r <= '0;
			pad_i_s2_r <= '0;
			pad_b_s1_r <= '0;
			pad_b_s2_r <= '0;
		end else begin
			pad_i_s1_r <= pad_i_in;
			pad_i_s2_r <= pad_i_s1_r;
			pad_b_s1_r <= pad_b_in;
			pad_b_s2_r <= pad_b_s1_r;
		end
	end

	// ****************************************
	// pin drive selection
	// ****************************************
	wire [N_OUT-1:0] lat_o = latch_copy_r[OUT_LSB +: N_OUT];
	wire [N_BIDI-1:0] lat_bd = latch_copy_r[BD_LSB +: N_BIDI];
	wire [N_BIDI-1:0] lat_be = latch_copy_r[BE_LSB +: N_BIDI];
	wire use_latch = mode_use_r.from_latch;
	wire float_all = mode_use_r.float_all;
	wire [N_OUT-1:0] o_out_nxt = use_latch ? lat_o : core_o_out;
	wire [N_OUT-1:0] o_oe_n_nxt = {N_OUT{float_all}};
	wire [N_BIDI-1:0] b_out_nxt = use_latch ? lat_bd : core_b_out;
	wire [N_BIDI-1:0] b_en = use_latch ? lat_be : core_b_oe;
	wire [N_BIDI-1:0] b_oe_n_nxt = float_all ? {N_BIDI{1'h1}} : ~b_en;

	logic [N_IN-1:0] core_i_in_r;
	logic [N_BIDI-1:0] core_b_in_r;
	logic [N_OUT-1:0] pad_o_out_r;
	logic [N_OUT-1:0] pad_o_oe_n_r;
	logic [N_BIDI-1:0] pad_b_out_r;
	logic [N_BIDI-1:0] pad_b_oe_n_r;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			core_i_in_r <= '0;
			core_b_in_r <= '0;
			pad_o_out_r <= '0;
			pad_o_oe_n_r <= '1;
			pad_b_out_r <= '0;
			pad_b_oe_n_r <= '1;
		end else begin
			core_i_in_r <= pad_i_s2_r;
			core_b_in_r <= pad_b_s2_r;
			pad_o_out_r <= o_out_nxt;
			pad_o_oe_n_r <= o_oe_n_nxt;
			pad_b_out_r <= b_out_nxt;
			pad_b_oe_n_r <= b_oe_n_nxt;
		end
	end

	assign core_i_in = core_i_in_r;
	assign core_b_in = core_b_in_r;
	assign pad_o_out = pad_o_out_r;
	assign pad_o_oe_n = pad_o_oe_n_r;
	assign pad_b_out = pad_b_out_r;
	assign pad_b_oe_n = pad_b_oe_n_r;

endmodule : boundary_scan_tap

`default_nettype wire

//--- rtl/bscan_params.svh
/*
 * constants of the boundary-scan test logic: instruction codes, the
 * capture-ir pattern, identification field positions, reset values.
 * assumes nothing beyond being included once by each file that needs it.
 */
`ifndef BSCAN_PARAMS_SVH
`define BSCAN_PARAMS_SVH

// ****************************************
// instruction register
// ****************************************
`define IR_WIDTH 6
`define OP_EXTEST 6'h00
`define OP_SAMPLE 6'h01
`define OP_IDCODE 6'h02
`define OP_FLOAT 6'h03
`define OP_CAPTURE_PATTERN 6'h2d
`define OP_CLAMP 6'h3e
`define OP_BYPASS 6'h3f

// ****************************************
// identification register layout
// ****************************************
`define ID_WIDTH 32
`define ID_LSB_VALUE 1'h1
`define ID_MANUF_LSB 1
`define ID_MANUF_WIDTH 11
`define ID_PART_LSB 12
`define ID_PART_WIDTH 16
`define ID_VER_LSB 28
`define ID_VER_WIDTH 4

// ****************************************
// reset values
// ****************************************
`define BYPASS_CAPTURE 1'h0
`define TDO_IDLE 1'h0

`endif

//--- rtl/bscan_pkg.sv
/*
 * types of the boundary-scan test logic.
 * assumes bscan_params.svh is on the include path.
 */
`default_nettype none

package bscan_pkg;

	// ****************************************
	// tap controller states
	// ****************************************
	typedef enum logic [3:0] {
		ST_RESET = 4'b0000,
		ST_IDLE = 4'b0001,
		ST_SEL_DR = 4'b0010,
		ST_CAP_DR = 4'b0011,
		ST_SH_DR = 4'b0100,
		ST_EX1_DR = 4'b0101,
		ST_PAU_DR = 4'b0110,
		ST_EX2_DR = 4'b0111,
		ST_UPD_DR = 4'b1000,
		ST_SEL_IR = 4'b1001,
		ST_CAP_IR = 4'b1010,
		ST_SH_IR = 4'b1011,
		ST_EX1_IR = 4'b1100,
		ST_PAU_IR = 4'b1101,
		ST_EX2_IR = 4'b1110,
		ST_UPD_IR = 4'b1111
	} tap_state_t;

	// ****************************************
	// pin mode handed to the system clock side
	// ****************************************
	typedef struct packed {
		logic from_latch;
		logic float_all;
	} pin_mode_t;

	// ****************************************
	// data register selection
	// ****************************************
	typedef struct packed {
		logic bsr;
		logic id;
		logic bypass;
	} dr_sel_t;

endpackage : bscan_pkg

`default_nettype wire

//--- rtl/scan_update_reg.sv
/*
 * boundary scan register: capture/shift stages on the rising test clock
 * and update stages latched on the falling test clock.
 * assumes control strobes come from the tap controller on the same clock.
 */
`default_nettype none

module scan_update_reg #(
	parameter int W = 8
) (
	// test clock and reset
	input wire logic tck,
	input wire logic trst_n,
	// controls
	input wire logic capture_en,
	input wire logic shift_en,
	input wire logic update_en,
	// serial and parallel data
	input wire logic tdi,
	input wire logic [W-1:0] capture_vec,
	output logic so,
	output logic [W-1:0] latch_vec
);

	logic [W-1:0] shift_r;
	logic [W-1:0] latch_r;

	// ****************************************
	// capture and shift stages
	// ****************************************
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			shift_r <= '0;
		end else if (capture_en) begin
			shift_r <= capture_vec;
		end else if (shift_en) begin
			shift_r <= {tdi, shift_r[W-1:1]};
		end
	end

	// ****************************************
	// update latches on the falling edge
	// ****************************************
	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			latch_r <= '0;
		end else if (update_en) begin
			latch_r <= shift_r;
		end
	end

	assign so = shift_r[0];
	assign latch_vec = latch_r;

endmodule : scan_update_reg

`default_nettype wire

//--- bench/bscan_checker.sv
/*
 * port assertions for the boundary-scan test logic.
 * assumes bscan_params.svh on the include path; bound into boundary_scan_tap.
 */
`default_nettype none
`include "bscan_params.svh"

module bscan_checker #(
	parameter int N_IN = 4,
	parameter int N_BIDI = 4
) (
	// clocks and resets
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic tck,
	input wire logic trst_n,
	// test port
	input wire logic tms,
	input wire logic tdo,
	input wire logic tdo_oe_n,
	// pins
	input wire logic [N_IN-1:0] pad_i_in,
	input wire logic [N_IN-1:0] core_i_in,
	input wire logic [N_BIDI-1:0] pad_b_in,
	input wire logic [N_BIDI-1:0] core_b_in
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [5:0] CAP = `OP_CAPTURE_PATTERN;
	logic [2:0] run_r;
	logic [2:0] run_nxt;
	assign run_nxt = (run_r == 3'h7) ? run_r : run_r + 3'h1;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			run_r <= 3'h0;
		end else begin
			run_r <= run_nxt;
		end
	end

	// ****************************************
	// tap sequences
	// ****************************************
	sequence s_reset5;
		tms [*5];
	endsequence
	sequence s_to_shift_dr;
		s_reset5 ##1 (!tms) [*2] ##1 tms ##1 (!tms) [*2];
	endsequence
	sequence s_to_shift_ir;
		s_reset5 ##1 (!tms) [*2] ##1 tms [*2] ##1 (!tms) [*2];
	endsequence

	// ****************************************
	// properties
	// ****************************************
	property p_tdo_idle;
		@(posedge tck) disable iff (!trst_n) tdo_oe_n |-> tdo == `TDO_IDLE;
	endproperty
	a_tdo_idle: assert property (p_tdo_idle)
		else $error("tdo not idle while disabled");
	property p_shift_entry;
		@(posedge tck) disable iff (!trst_n) !tdo_oe_n |-> !$past(tms);
	endproperty
	a_shift_entry: assert property (p_shift_entry)
		else $error("tdo enabled outside a shift state");
	property p_shift_exit;
		@(posedge tck) disable iff (!trst_n) !tdo_oe_n && tms |=> tdo_oe_n;
	endproperty
	a_shift_exit: assert property (p_shift_exit)
		else $error("tdo still enabled after leaving shift");
	property p_five_ones;
		@(posedge tck) disable iff (!trst_n) s_reset5 |=> tdo_oe_n;
	endproperty
	a_five_ones: assert property (p_five_ones)
		else $error("five ones on tms did not reset");
	property p_trst_low;
		@(posedge mclk) disable iff (!rst_n) !trst_n |-> tdo_oe_n && tdo == `TDO_IDLE;
	endproperty
	a_trst_low: assert property (p_trst_low)
		else $error("test reset did not quiet tdo");
	property p_id_first;
		@(posedge tck) disable iff (!trst_n) s_to_shift_dr |=> !tdo_oe_n && tdo == `ID_LSB_VALUE;
	endproperty
	a_id_first: assert property (p_id_first)
		else $error("first id bit wrong after reset");
	property p_ir_pattern;
		@(posedge tck) disable iff (!trst_n) s_to_shift_ir |=> tdo == CAP[0] ##1 tdo == CAP[1];
	endproperty
	a_ir_pattern: assert property (p_ir_pattern)
		else $error("capture pattern low bits wrong");
	property p_in_observe;
		@(posedge mclk) disable iff (!rst_n) run_r > 3'h3 |-> core_i_in == $past(pad_i_in, 3);
	endproperty
	a_in_observe: assert property (p_in_observe)
		else $error("input pin not passed to core");
	property p_bidi_in;
		@(posedge mclk) disable iff (!rst_n) run_r > 3'h3 |-> core_b_in == $past(pad_b_in, 3);
	endproperty
	a_bidi_in: assert property (p_bidi_in)
		else $error("two-way pin not passed to core");
endmodule : bscan_checker

bind boundary_scan_tap bscan_checker #(.N_IN(N_IN), .N_BIDI(N_BIDI)) chk (
	.mclk(mclk), .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tms(tms), .tdo(tdo),
	.tdo_oe_n(tdo_oe_n), .pad_i_in(pad_i_in), .core_i_in(core_i_in),
	.pad_b_in(pad_b_in), .core_b_in(core_b_in)
);

`default_nettype wire

//--- bench/scan_tester.sv
/*
 * board tester model: runs tck only within frames, drives tms/tdi, reads tdo.
 * assumes the device changes tdo on the falling tck edge.
 */
`default_nettype none

module scan_tester (
	// test port
	output logic tck,
	output logic trst_n,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 16;
	initial begin
		tck = 1'b0;
		trst_n = 1'b1;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// one tck cycle, tdo read just before the rising edge
	task automatic step(input logic m, input logic di, output logic o);
		tms = m;
		tdi = di;
		#(HALF);
		o = tdo;
		tck = 1'b1;
		#(HALF);
		tck = 1'b0;
	endtask : step
	task automatic tap_reset();
		logic o;
		trst_n = 1'b0;
		#(200);
		trst_n = 1'b1;
		#(HALF);
		repeat (5) step(1'b1, 1'b1, o);
	endtask : tap_reset
	// idle, capture, shift n bits lsb first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic o;
		dout = '0;
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b1, 1'b1, o);
		if (ir) begin
			step(1'b1, 1'b1, o);
		end
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask : scan
endmodule : scan_tester

`default_nettype wire

//--- bench/test_boundary_scan_tap.sv
/*
 * self-checking bench for boundary_scan_tap with a tester model.
 * assumes bscan_params.svh on the include path.
 */
`default_nettype none
`include "bscan_params.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, e); end end

module test_boundary_scan_tap;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] VER = 4'h6; // arbitrary value
	localparam logic [15:0] PART = 16'h5a3c; // arbitrary value
	localparam logic [10:0] MAKER = 11'h2b1; // arbitrary value
	localparam logic [31:0] ID_EXP = {VER, PART, MAKER, `ID_LSB_VALUE};
	localparam logic [5:0] OPS [5] = '{6'h3f, 6'h04, 6'h2c, 6'h2e, 6'h3d};
	logic mclk, rst_n, tck, trst_n, tms, tdi, tdo, tdo_oe_n;
	logic [3:0] pad_i_in, core_i_in, core_o_out, pad_o_out, pad_o_oe_n, ext_b;
	logic [3:0] core_b_out, core_b_oe, core_b_in, pad_b_in, pad_b_out, pad_b_oe_n;
	logic [31:0] seed, act, e, d, p, q, r;
	logic [31:0] exp_q [$];
	int fail_count, checks;
	event shown;
	// two-way wire: device drives when enabled, board value otherwise
	assign pad_b_in = (~pad_b_oe_n & pad_b_out) | (pad_b_oe_n & ext_b);
	boundary_scan_tap #(.N_IN(4), .N_OUT(4), .N_BIDI(4), .ID_VERSION(VER),
		.ID_PART(PART), .ID_MANUF(MAKER)) dut (
		.mclk(mclk), .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe_n(tdo_oe_n), .pad_i_in(pad_i_in), .core_i_in(core_i_in),
		.core_o_out(core_o_out), .pad_o_out(pad_o_out), .pad_o_oe_n(pad_o_oe_n),
		.core_b_out(core_b_out), .core_b_oe(core_b_oe), .core_b_in(core_b_in),
		.pad_b_in(pad_b_in), .pad_b_out(pad_b_out), .pad_b_oe_n(pad_b_oe_n));
	scan_tester tester (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		repeat (9) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd
	function automatic logic [31:0] normal();
		return {20'h0, ~core_b_oe, core_b_out, core_o_out};
	endfunction : normal
	function automatic logic [31:0] latched(input logic [31:0] v);
		return {20'h0, ~v[15:12], v[11:8], v[7:4]};
	endfunction : latched
	function automatic logic [31:0] bsr(input logic [3:0] o, en, dat);
		return {16'h0, en, (en & dat) | (~en & ext_b), o, pad_i_in};
	endfunction : bsr
	task automatic note(input logic [31:0] v);
		exp_q.push_back(v);
	endtask : note
	task automatic show(input logic [31:0] v);
		act = v;
		-> shown;
		#1;
	endtask : show
	task automatic show_pins();
		repeat (8) @(negedge mclk);
		show({16'h0, pad_o_oe_n, pad_b_oe_n, pad_b_out, pad_o_out});
	endtask : show_pins
	task automatic newpins();
		@(negedge mclk);
		r = rnd();
		{ext_b, core_b_oe, core_b_out, core_o_out, pad_i_in} <= r[19:0];
		repeat (8) @(negedge mclk);
	endtask : newpins
	task automatic ir(input logic [5:0] op);
		tester.scan(1'b1, 6, {26'h0, op}, d);
		note({26'h0, `OP_CAPTURE_PATTERN});
		show(d);
	endtask : ir
	task automatic dr(input int n, input logic [31:0] din, input logic [31:0] ev);
		tester.scan(1'b0, n, din, d);
		note(ev);
		show(d);
	endtask : dr
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish
	always @(shown) begin
		e = exp_q.pop_front();
		`CHK(act, e)
	end
	initial begin
		#1000000;
		fail_count++;
		tally_and_finish();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		seed = 32'hfda6;
		rst_n = 1'b0;
		{ext_b, core_b_oe, core_b_out, core_o_out, pad_i_in} = 20'h0;
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		tester.tap_reset();
		newpins();
		dr(32, rnd(), ID_EXP);
		tester.tap_reset();
		ir(`OP_IDCODE);
		dr(32, rnd(), ID_EXP);
		foreach (OPS[i]) begin
			newpins();
			ir(OPS[i]);
			q = rnd();
			dr(8, q, {24'h0, q[6:0], `BYPASS_CAPTURE});
			note(normal());
			show_pins();
		end
		newpins();
		ir(`OP_SAMPLE);
		p = rnd();
		dr(16, p, bsr(core_o_out, core_b_oe, core_b_out));
		note(normal());
		show_pins();
		ir(`OP_EXTEST);
		newpins();
		note(latched(p));
		show_pins();
		q = rnd();
		dr(16, q, bsr(p[7:4], p[15:12], p[11:8]));
		note(latched(q));
		show_pins();
		ir(`OP_CLAMP);
		p = rnd();
		dr(8, p, {24'h0, p[6:0], `BYPASS_CAPTURE});
		newpins();
		note(latched(q));
		show_pins();
		ir(`OP_FLOAT);
		repeat (8) @(negedge mclk);
		note(32'hff);
		show({24'h0, pad_o_oe_n, pad_b_oe_n});
		ir(`OP_BYPASS);
		note(normal());
		show_pins();
		tally_and_finish();
	end
endmodule : test_boundary_scan_tap

`default_nettype wire
